// >>> shared/umd_pkg.sv
package umd_pkg;
  // word offsets from the system word base
  localparam logic [5:0] BUF_FIRST = 6'd9;
  localparam logic [5:0] BUF_LAST = 6'd40;
  localparam int LINES = 4;
  localparam int COLS = 16;
  localparam int WORDS_PER_LINE = 8;
  localparam int BUF_WORDS = 32;
  // flag offsets from the system flag base
  localparam int FLAG_REQ = 4;
  localparam int FLAG_STAT = 6;
  // allowed single-byte code ranges
  localparam logic [7:0] ASC_LO = 8'h20;
  localparam logic [7:0] ASC_HI = 8'h7D;
  localparam logic [7:0] KANA_LO = 8'hA1;
  localparam logic [7:0] KANA_HI = 8'hDF;
  localparam logic [7:0] SPACE = 8'h20;
  // double-byte lead byte ranges
  localparam logic [7:0] LEAD1_LO = 8'h81;
  localparam logic [7:0] LEAD1_HI = 8'h9F;
  localparam logic [7:0] LEAD2_LO = 8'hE0;
  localparam logic [7:0] LEAD2_HI = 8'hEF;
  // screen codes, gray along main -> message -> menu
  typedef enum logic [1:0] {
    UMD_MAIN = 2'b00,
    UMD_MSG = 2'b01,
    UMD_MENU = 2'b11,
    UMD_MON = 2'b10
  } umd_screen_t;
endpackage

// >>> src/umd_display.sv
`timescale 1ns/100ps
`default_nettype none
// Operation
// R1: show codes 20-7D and A1-DF directly
// R2: accept double-byte characters over two columns
// R3: buffer words 9..40, eight per line
// R4: low byte left, high byte right
// R5: request flag enters message from main only
// R6: request off returns to main screen
// R7: status flag on for message or monitor
// R8: double-byte across line end shows spaces
// R9: program avoids double-byte across line ends
// R10: program copies 32-word message into buffer
// R11: other screens block message despite request
// R12: OK button goes from message to menu
// R13: buffer re-read on every refresh; a refresh that comes during a pass is ignored
module umd_display (
  input wire logic sys_clk, // 20 MHz
  input wire logic sys_rst, // sync, active high
  input wire logic req_flag, // display request flag, system flag 4
  input wire logic ok_btn, // OK button pulse from key logic
  input wire logic menu_exit, // menu logic returns to main screen
  input wire logic mon_enter, // device monitor screen selected
  input wire logic refresh, // start one display refresh pulse
  output logic [5:0] buf_addr, // word offset being fetched
  input wire logic [15:0] buf_data, // word at buf_addr, same cycle
  output logic [1:0] char_row, // row of char_out
  output logic [3:0] char_col, // column of char_out
  output logic [7:0] char_out, // code for that position
  output logic char_we, // char_out valid pulse
  output logic status_flag, // system flag 6
  output logic msg_active // message screen shown
);
  umd_pkg::umd_screen_t scr_q, scr_d;
  logic [4:0] idx_q, idx_d;
  logic busy_q, busy_d;
  logic hi_q, hi_d;
  logic [7:0] hib_q, hib_d;
  logic lead_q, lead_d;
  logic [1:0] row_q, row_d;
  logic [3:0] col_q, col_d;
  logic [7:0] chr_q, chr_d;
  logic we_q, we_d;

  // double-byte lead codes; the byte after one is always taken as its trail
  function automatic logic is_lead(input logic [7:0] b);
    is_lead = (b >= umd_pkg::LEAD1_LO && b <= umd_pkg::LEAD1_HI) ||
              (b >= umd_pkg::LEAD2_LO && b <= umd_pkg::LEAD2_HI);
  endfunction

  // single-byte codes that have a glyph; any other byte that is neither a lead nor its trail shows as a space
  function automatic logic is_single(input logic [7:0] b);
    is_single = (b >= umd_pkg::ASC_LO && b <= umd_pkg::ASC_HI) ||
                (b >= umd_pkg::KANA_LO && b <= umd_pkg::KANA_HI);
  endfunction

  // a lead byte in the high half of a line's last word would straddle two rows
  function automatic logic splits_line(input logic [7:0] b, input logic [4:0] idx);
    splits_line = is_lead(b) && idx[2:0] == 3'h7;
  endfunction

  // screen selection; the message screen is reachable from main only, so a
  // request that stands while a menu or the monitor is up waits for main again
  always_comb begin
    scr_d = scr_q;
    unique case (scr_q)
      umd_pkg::UMD_MAIN: begin
        if (mon_enter) scr_d = umd_pkg::UMD_MON;
        else if (req_flag) scr_d = umd_pkg::UMD_MSG; // [R5]
      end
      umd_pkg::UMD_MSG: begin
        if (!req_flag) scr_d = umd_pkg::UMD_MAIN; // [R6]
        else if (ok_btn) scr_d = umd_pkg::UMD_MENU; // [R12]
      end
      umd_pkg::UMD_MENU: begin
        // request stays ignored here until main returns [R11]
        if (menu_exit) scr_d = umd_pkg::UMD_MAIN;
      end
      umd_pkg::UMD_MON: begin
        if (menu_exit) scr_d = umd_pkg::UMD_MAIN; // [R11]
      end
    endcase
  end

  // screen register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) scr_q <= umd_pkg::UMD_MAIN;
    else scr_q <= scr_d;
  end

  // refresh walker: each word gives two characters over two cycles
  always_comb begin
    idx_d = idx_q;
    busy_d = busy_q;
    hi_d = hi_q;
    hib_d = hib_q;
    lead_d = lead_q;
    row_d = row_q;
    col_d = col_q;
    chr_d = chr_q;
    we_d = 1'b0;
    if (!busy_q) begin
      // refresh outside the message screen is refused [R11]
      // fresh pass per refresh taken while idle so program writes show at once [R13]
      if (refresh && scr_q == umd_pkg::UMD_MSG) begin
        busy_d = 1'b1;
        idx_d = 5'd0;
        hi_d = 1'b0;
        lead_d = 1'b0;
      end
    end else begin
      we_d = 1'b1;
      row_d = idx_q[4:3]; // [R3]
      col_d = {idx_q[2:0], hi_q}; // [R4]
      if (!hi_q) begin
        // low byte in left column [R4]
        hib_d = buf_data[15:8];
        if (lead_q) begin
          chr_d = buf_data[7:0]; // trail byte of double-byte [R2]
          lead_d = 1'b0;
        end else if (is_lead(buf_data[7:0])) begin
          chr_d = buf_data[7:0]; // [R2]
          lead_d = 1'b1;
        end else if (is_single(buf_data[7:0])) begin
          chr_d = buf_data[7:0]; // [R1]
        end else begin
          chr_d = umd_pkg::SPACE;
        end
        hi_d = 1'b1;
      end else begin
        if (lead_q) begin
          chr_d = hib_q; // [R2]
          lead_d = 1'b0;
        end else if (is_lead(hib_q)) begin
          if (splits_line(hib_q, idx_q)) begin
            // lead in last column: blank it and its trail [R8]
            chr_d = umd_pkg::SPACE;
            lead_d = 1'b0;
          end else begin
            chr_d = hib_q;
            lead_d = 1'b1;
          end
        end else if (is_single(hib_q)) begin
          chr_d = hib_q; // [R1]
        end else begin
          chr_d = umd_pkg::SPACE;
        end
        hi_d = 1'b0;
        idx_d = 5'(idx_q + 5'd1);
        if (idx_q == 5'(umd_pkg::BUF_WORDS - 1)) busy_d = 1'b0;
      end
    end
  end

  // trail of a blanked lead: next line's first byte becomes space [R8]
  // the trail is fetched a cycle later with the next word, so the blanking
  // decision is carried across that word boundary in a flag
  logic blank_q, blank_d;
  always_comb begin
    blank_d = blank_q;
    if (busy_q && hi_q) blank_d = splits_line(hib_q, idx_q) && !lead_q;
    else if (busy_q && !hi_q) blank_d = 1'b0;
    else if (!busy_q) blank_d = 1'b0;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      idx_q <= 5'd0;
      busy_q <= 1'b0;
      hi_q <= 1'b0;
      hib_q <= 8'h00;
      lead_q <= 1'b0;
      row_q <= 2'd0;
      col_q <= 4'd0;
      chr_q <= 8'h00;
      we_q <= 1'b0;
      blank_q <= 1'b0;
    end else begin
      idx_q <= idx_d;
      // leaving the message screen cuts a pass at the same edge, but the character
      // registered in its last cycle still goes out after the new screen is up [R6]
      busy_q <= busy_d && scr_d == umd_pkg::UMD_MSG;
      hi_q <= hi_d;
      hib_q <= hib_d;
      // a blanked pair must not leave its trail treated as a lead
      lead_q <= blank_d ? 1'b1 : lead_d;
      row_q <= row_d;
      col_q <= col_d;
      chr_q <= (blank_q && !hi_q) ? umd_pkg::SPACE : chr_d; // [R8]
      we_q <= we_d;
      blank_q <= blank_d;
    end
  end

  // screen flags come straight from the state register, so they never glitch
  // with the inputs; status covers both screens that software may watch [R7]
  logic show_msg, show_stat;
  always_comb begin
    show_msg = 1'b0;
    show_stat = 1'b0;
    unique case (scr_q)
      umd_pkg::UMD_MSG: begin
        show_msg = 1'b1;
        show_stat = 1'b1;
      end
      umd_pkg::UMD_MON: show_stat = 1'b1;
      umd_pkg::UMD_MAIN, umd_pkg::UMD_MENU: show_stat = 1'b0;
    endcase
  end

  // position and code go out straight from registers
  assign buf_addr = 6'(umd_pkg::BUF_FIRST + {1'b0, idx_q}); // [R3]
  assign char_row = row_q;
  assign char_col = col_q;
  assign char_out = chr_q;
  assign char_we = we_q;
  assign msg_active = show_msg;
  assign status_flag = show_stat; // [R7]
endmodule
`default_nettype wire

// >>> verif/umd_display_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module umd_display_asserts (
  input wire logic sys_clk, // clock
  input wire logic sys_rst, // reset
  input wire logic req_flag, // request
  input wire logic ok_btn, // ok key
  input wire logic refresh, // pass start
  input wire logic [5:0] buf_addr, // fetch
  input wire logic [1:0] char_row, // row
  input wire logic [3:0] char_col, // col
  input wire logic char_we, // strobe
  input wire logic status_flag, // flag 6
  input wire logic msg_active // shown
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  stat_msg_a: assert property (msg_active |-> status_flag)
    else $error("status low");
  enter_main_a: assert property ($rose(msg_active) |-> $past(req_flag) && !$past(status_flag))
    else $error("bad entry");
  leave_req_a: assert property (msg_active && !req_flag |=> !msg_active)
    else $error("no leave");
  ok_menu_a: assert property (msg_active && req_flag && ok_btn |=> !status_flag)
    else $error("no menu");
  col_step_a: assert property (char_we && char_col != 4'hF ##1 char_we
    |-> char_col == $past(char_col) + 4'h1)
    else $error("col order");
  row_step_a: assert property (char_we && char_col == 4'hF ##1 char_we
    |-> char_col == 4'h0 && char_row == $past(char_row) + 2'h1)
    else $error("row order");
  word_map_a: assert property (char_we && !char_col[0]
    |-> $past(buf_addr) == {char_row, char_col[3:1]} + 6'h09)
    else $error("word map");
  pass_run_a: assert property (char_we && char_col != 4'hF |=> char_we || !msg_active)
    else $error("gap");
  cover property ($rose(msg_active));
  cover property (msg_active && refresh);
  cover property (char_we && char_row == 2'h3 && char_col == 4'hF);
endmodule
bind umd_display umd_display_asserts i_umd_display_asserts (.*);
`default_nettype wire

// >>> verif/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic sys_clk, sys_rst, req_flag, ok_btn, menu_exit, mon_enter, refresh;
  logic char_we, status_flag, msg_active;
  logic [5:0] buf_addr;
  logic [15:0] buf_data;
  logic [1:0] char_row;
  logic [3:0] char_col;
  logic [7:0] char_out;
  logic [15:0] mem [0:31];
  logic [7:0] exp_c [0:63];
  int err_total, tests_run;
  // buffer read is combinational, as the fetch expects
  assign buf_data = mem[buf_addr - 6'h09];
  umd_display i_umd_display (.*);
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    tests_run++;
    if (seen !== want) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, seen, want);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic look();
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  // screen moves: request, ok to menu, menu back, monitor
  task automatic t_screens();
    @(posedge sys_clk) req_flag <= 1'b1;
    look();
    chk(msg_active, 1'b1);
    chk(status_flag, 1'b1);
    @(posedge sys_clk) ok_btn <= 1'b1;
    @(posedge sys_clk) ok_btn <= 1'b0;
    look();
    chk(msg_active, 1'b0);
    chk(status_flag, 1'b0);
    @(posedge sys_clk) menu_exit <= 1'b1;
    @(posedge sys_clk) menu_exit <= 1'b0;
    look();
    chk(msg_active, 1'b1);
    @(posedge sys_clk) req_flag <= 1'b0;
    look();
    chk(msg_active, 1'b0);
    @(posedge sys_clk) mon_enter <= 1'b1;
    @(posedge sys_clk) mon_enter <= 1'b0;
    look();
    chk(status_flag, 1'b1);
    chk(msg_active, 1'b0);
    @(posedge sys_clk) menu_exit <= 1'b1;
    @(posedge sys_clk) menu_exit <= 1'b0;
    @(posedge sys_clk) req_flag <= 1'b1;
    look();
  endtask
  // refresh after leaving the message screen must write nothing
  task automatic t_refuse();
    int n;
    n = 0;
    @(posedge sys_clk) req_flag <= 1'b0;
    @(posedge sys_clk) refresh <= 1'b1;
    @(posedge sys_clk) refresh <= 1'b0;
    repeat (10) begin
      @(negedge sys_clk);
      if (char_we !== 1'b0) n++;
    end
    chk(8'(n), 8'h00);
    chk(msg_active, 1'b0);
    @(posedge sys_clk) req_flag <= 1'b1;
    look();
  endtask
  // one refresh pass judged against the expected image
  task automatic t_pass();
    int n;
    n = 0;
    @(posedge sys_clk) refresh <= 1'b1;
    @(posedge sys_clk) refresh <= 1'b0;
    repeat (80) begin
      @(negedge sys_clk);
      if (char_we === 1'b1) begin
        chk(char_out, exp_c[{char_row, char_col}]);
        n++;
      end
    end
    chk(8'(n), 8'h40);
  endtask
  initial begin
    err_total = 0;
    tests_run = 0;
    {req_flag, ok_btn, menu_exit, mon_enter, refresh} = '0;
    sys_rst = 1'b1;
    for (int k = 0; k < 32; k++) mem[k] = 16'h4241;
    mem[1] = 16'h4081;
    mem[2] = 16'hA07E;
    mem[3] = 16'hDFA1;
    mem[4] = 16'h7D20;
    mem[7] = 16'h8141;
    for (int k = 0; k < 64; k++) exp_c[k] = mem[k / 2][8 * (k % 2) +: 8];
    // bad codes, the split lead byte and its trail become spaces
    exp_c[4] = 8'h20;
    exp_c[5] = 8'h20;
    exp_c[15] = 8'h20;
    exp_c[16] = 8'h20;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_screens();
    t_pass();
    t_refuse();
    mem[0] = 16'h5A59;
    exp_c[0] = 8'h59;
    exp_c[1] = 8'h5A;
    t_pass();
    complete_run();
  end
endmodule
`default_nettype wire
